/* File: tbf_defines.svh */
// Purpose: constants of the token bus frame block
// Assumes: octet bit 7 is the first symbol sent
// Notes:   symbols are 2 bits: 00 zero, 01 one, 10 non-data
`ifndef TBF_DEFINES_SVH
`define TBF_DEFINES_SVH
`define TBF_SYM_ZERO   2'h0
`define TBF_SYM_ONE    2'h1
`define TBF_SYM_ND     2'h2
`define TBF_SD_SYMS    16'hA280
`define TBF_ED_SYMS    16'hA6A4
`define TBF_ED_MASK    16'hFFF0
`define TBF_MAX_DATA   14'h1FFF
`define TBF_FCS_LEN    14'h0004
`define TBF_SHORT_ADDR 14'h0002
`define TBF_LONG_ADDR  14'h0006
`define TBF_PRE_NS     2000
`define TBF_FF_CTRL    2'h0
`define TBF_FF_LLC     2'h1
`define TBF_C_CLAIM    6'h00
`define TBF_C_SOL1     6'h01
`define TBF_C_SOL2     6'h02
`define TBF_C_WHO      6'h03
`define TBF_C_RESOLVE  6'h04
`define TBF_C_TOKEN    6'h08
`define TBF_C_SETSUCC  6'h0C
`endif

/* File: tbf_pkg.sv */
// Purpose: types of the token bus frame block
// Assumes: nothing
// Notes:   class codes are an internal encoding; FC_SOL1..FC_RESOLVE follow FC_CLAIM in type order
package tbf_pkg;
    typedef enum logic [4:0] {
        TX_IDLE = 5'h01,
        TX_PRE  = 5'h02,
        TX_SD   = 5'h04,
        TX_BODY = 5'h08,
        TX_ED   = 5'h10
    } tbf_tx_e;
    typedef enum logic [1:0] {
        RX_HUNT  = 2'h1,
        RX_FRAME = 2'h2
    } tbf_rx_e;
    typedef enum logic [3:0] {
        FC_NONE, FC_CLAIM, FC_SOL1, FC_SOL2, FC_WHO,
        FC_RESOLVE, FC_TOKEN, FC_SETSUCC, FC_LLC, FC_OTHER
    } tbf_class_e;
endpackage

/* File: tbf_framer.sv */
// Purpose: token bus frame assembly and parsing
// Assumes: check sequence made and checked outside; modem on clk_i
// Notes:   the four octets before the end delimiter are the check sequence
// Summary of operation
// - fields in fixed order, sd to ed
// - addresses two or six octets each
// - data frame body at most 8191 octets
// - abort is start then end delimiter only
// - valid needs all fields, good check
// - preamble of pad idle before frames
// - receiver ignores symbols between frames
// - post silence frame uses configured preamble
// - preamble whole octets, at least 2 us
// - claim token uses exactly minimum preamble
// - start delimiter is N N 0 N N 0 0 0
// - frame control selects control or data
// - control frame: 00 then six-bit type
// - type 000000 is claim token
// - types 1..4 with 1..4 response windows
// - 001000 token, 001100 set successor
// - data frame: 01, action, priority
`timescale 1ns/1ns
`include "tbf_defines.svh"

module tbf_fifo #(
    parameter int W = 10,
    parameter int D = 4
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    output logic [W-1:0]      out_data_o,
    output logic              out_valid_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  cnt_q;
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic         push;
    logic         pop;
    assign in_ready_o  = (cnt_q != (AW+1)'(D));
    assign out_valid_o = (cnt_q != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem[rp_q];
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem[wp_q] <= in_data_i;
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_q <= '0;
            wp_q  <= '0;
            rp_q  <= '0;
        end
        else
        begin
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
            if (push)
            begin
                wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop)
            begin
                rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
            end
        end
    end
endmodule // tbf_fifo

////////////////////////////////////////////////////////////////////////////////

module tbf_framer import tbf_pkg::*; #(
    parameter int RATE_MBPS = 10,
    parameter int GAP_CYC   = 64,
    parameter int DEPTH     = 4
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        addr_long_i,
    input  wire logic [7:0]  post_sil_pre_i,
    input  wire logic [7:0]  tx_data_i,
    input  wire logic        tx_valid_i,
    input  wire logic        tx_last_i,
    output logic             tx_ready_o,
    input  wire logic        tx_abort_i,
    output logic [15:0]      tx_sym_o,
    output logic             tx_valid_o,
    input  wire logic        tx_ready_i,
    input  wire logic [15:0] rx_sym_i,
    input  wire logic        rx_valid_i,
    output logic             rx_ready_o,
    input  wire logic        rx_fcs_ok_i,
    output logic [7:0]       rx_data_o,
    output logic             rx_end_o,
    output logic             rx_good_o,
    output logic             rx_valid_o,
    input  wire logic        rx_ready_i,
    output tbf_class_e       rx_class_o,
    output logic [2:0]       rx_windows_o
);
    // ceiling keeps whole octets and never under 2 us
    localparam logic [7:0] PRE_MIN = 8'((`TBF_PRE_NS * RATE_MBPS + 7999) / 8000);

    function automatic logic [15:0] to_syms(input logic [7:0] b);
        logic [15:0] s;
        s = '0;
        for (int i = 0; i < 8; i++)
        begin
            s[2*i +: 2] = b[i] ? `TBF_SYM_ONE : `TBF_SYM_ZERO;
        end
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // transmit side
    tbf_tx_e    tx_st_q;
    logic [7:0] pre_left_q;
    logic [7:0] pre_sent_q;
    logic       abort_q;
    logic       silence_q;
    logic [$clog2(GAP_CYC+1)-1:0] gap_q;
    logic       out_free;
    logic       is_claim;
    logic [7:0] pre_len;

    assign out_free   = !tx_valid_o || tx_ready_i;
    assign tx_ready_o = (tx_st_q == TX_BODY) && out_free;
    assign is_claim   = tx_data_i == {`TBF_FF_CTRL, `TBF_C_CLAIM};
    always_comb
    begin
        pre_len = PRE_MIN;
        if (silence_q && !is_claim && post_sil_pre_i > PRE_MIN)
        begin
            pre_len = post_sil_pre_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tx_st_q    <= TX_IDLE;
            pre_left_q <= '0;
            pre_sent_q <= '0;
            abort_q    <= 1'b0;
            tx_sym_o   <= '0;
            tx_valid_o <= 1'b0;
        end
        else if (out_free)
        begin
            tx_valid_o <= 1'b0;
            case (tx_st_q)
                TX_IDLE:
                begin
                    // abort is only ever a bare start/end pair
                    if (tx_abort_i || tx_valid_i)
                    begin
                        abort_q    <= tx_abort_i;
                        pre_left_q <= tx_abort_i ? PRE_MIN : pre_len;
                        pre_sent_q <= '0;
                        tx_st_q    <= TX_PRE;
                    end
                end
                TX_PRE:
                begin
                    tx_sym_o   <= '0;
                    tx_valid_o <= 1'b1;
                    pre_sent_q <= pre_sent_q + 8'h01;
                    pre_left_q <= pre_left_q - 8'h01;
                    if (pre_left_q == 8'h01)
                    begin
                        tx_st_q <= TX_SD;
                    end
                end
                TX_SD:
                begin
                    tx_sym_o   <= `TBF_SD_SYMS;
                    tx_valid_o <= 1'b1;
                    tx_st_q    <= abort_q ? TX_ED : TX_BODY;
                end
                TX_BODY:
                begin
                    // fields pass straight through in source order
                    if (tx_valid_i)
                    begin
                        tx_sym_o   <= to_syms(tx_data_i);
                        tx_valid_o <= 1'b1;
                        if (tx_last_i)
                        begin
                            tx_st_q <= TX_ED;
                        end
                    end
                end
                TX_ED:
                begin
                    tx_sym_o   <= `TBF_ED_SYMS;
                    tx_valid_o <= 1'b1;
                    tx_st_q    <= TX_IDLE;
                end
                default:
                begin
                    tx_st_q <= TX_IDLE;
                end
            endcase
        end
    end

    // silence means nothing offered to the modem for GAP_CYC+1 cycles in idle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            silence_q <= 1'b1;
            gap_q     <= '0;
        end
        else if (tx_valid_o)
        begin
            silence_q <= 1'b0;
            gap_q     <= '0;
        end
        else if (tx_st_q == TX_IDLE)
        begin
            if (gap_q == ($clog2(GAP_CYC+1))'(GAP_CYC))
            begin
                silence_q <= 1'b1;
            end
            else
            begin
                gap_q <= gap_q + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive side
    tbf_rx_e     rx_st_q;
    logic [13:0] cnt_q;
    logic [31:0] hold_q;
    logic [7:0]  fc_q;
    logic        dlv_q;
    logic        over_q;
    logic        is_sd;
    logic        is_ed;
    logic        is_dat;
    logic [7:0]  rx_byte;
    logic        take;
    logic        f_push;
    logic [9:0]  f_word;
    logic        f_ready;
    logic [9:0]  f_out;
    logic [13:0] min_len;

    assign is_sd   = rx_sym_i == `TBF_SD_SYMS;
    assign is_ed   = (rx_sym_i & `TBF_ED_MASK) == (`TBF_ED_SYMS & `TBF_ED_MASK);
    assign take    = rx_valid_i && rx_ready_o;
    assign min_len = 14'h0001 + `TBF_FCS_LEN
                   + (addr_long_i ? `TBF_LONG_ADDR + `TBF_LONG_ADDR
                                  : `TBF_SHORT_ADDR + `TBF_SHORT_ADDR);
    always_comb
    begin
        is_dat = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            rx_byte[i] = rx_sym_i[2*i];
            if (rx_sym_i[2*i+1])
            begin
                is_dat = 1'b0;
            end
        end
    end

    // four octets lag behind so the check sequence is never delivered
    always_comb
    begin
        f_push = 1'b0;
        f_word = {2'b00, hold_q[31:24]};
        if (take && rx_st_q == RX_FRAME)
        begin
            if (is_dat && !over_q && cnt_q >= `TBF_FCS_LEN)
            begin
                f_push = 1'b1;
            end
            else if (!is_dat && dlv_q)
            begin
                f_push = 1'b1;
                f_word = {1'b1, is_ed && rx_fcs_ok_i && !over_q && cnt_q >= min_len, 8'h00};
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_st_q <= RX_HUNT;
            cnt_q   <= '0;
            hold_q  <= '0;
            fc_q    <= '0;
            dlv_q   <= 1'b0;
            over_q  <= 1'b0;
        end
        else if (take)
        begin
            case (rx_st_q)
                RX_HUNT:
                begin
                    // preamble and stray symbols are dropped here
                    if (is_sd)
                    begin
                        rx_st_q <= RX_FRAME;
                        cnt_q   <= '0;
                        dlv_q   <= 1'b0;
                        over_q  <= 1'b0;
                    end
                end
                RX_FRAME:
                begin
                    if (is_dat)
                    begin
                        hold_q <= {hold_q[23:0], rx_byte};
                        cnt_q  <= cnt_q + 14'h0001;
                        dlv_q  <= dlv_q || f_push;
                        if (cnt_q == '0)
                        begin
                            fc_q <= rx_byte;
                        end
                        if (fc_q[7:6] == `TBF_FF_LLC && cnt_q >= `TBF_MAX_DATA)
                        begin
                            over_q <= 1'b1;
                        end
                    end
                    else
                    begin
                        // a new start delimiter restarts; anything else ends
                        rx_st_q <= is_sd ? RX_FRAME : RX_HUNT;
                        cnt_q   <= '0;
                        dlv_q   <= 1'b0;
                        over_q  <= 1'b0;
                    end
                end
                default:
                begin
                    rx_st_q <= RX_HUNT;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_class_o   <= FC_NONE;
            rx_windows_o <= '0;
        end
        else if (take && rx_st_q == RX_FRAME && is_dat && cnt_q == '0)
        begin
            rx_windows_o <= '0;
            rx_class_o   <= FC_OTHER;
            if (rx_byte[7:6] == `TBF_FF_LLC)
            begin
                rx_class_o <= FC_LLC;
            end
            else if (rx_byte[7:6] == `TBF_FF_CTRL)
            begin
                case (rx_byte[5:0])
                    `TBF_C_CLAIM:   rx_class_o <= FC_CLAIM;
                    `TBF_C_SOL1,
                    `TBF_C_SOL2,
                    `TBF_C_WHO,
                    `TBF_C_RESOLVE:
                    begin
                        rx_class_o   <= tbf_class_e'(4'(rx_byte[2:0]) + 4'(FC_CLAIM));
                        rx_windows_o <= rx_byte[2:0];
                    end
                    `TBF_C_TOKEN:   rx_class_o <= FC_TOKEN;
                    `TBF_C_SETSUCC: rx_class_o <= FC_SETSUCC;
                    default:        rx_class_o <= FC_OTHER;
                endcase
            end
        end
    end

    // the modem must hold symbols while the buffer is full
    assign rx_ready_o = f_ready;
    tbf_fifo #(.W(10), .D(DEPTH)) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_data_i   (f_word),
        .in_valid_i  (f_push),
        .in_ready_o  (f_ready),
        .out_data_o  (f_out),
        .out_valid_o (rx_valid_o),
        .out_ready_i (rx_ready_i)
    );
    assign rx_data_o = f_out[7:0];
    assign rx_end_o  = f_out[9];
    assign rx_good_o = f_out[8];

    ////////////////////////////////////////////////////////////////////////////
    sequence sd_out_s;
        tx_valid_o && tx_ready_i && tx_sym_o == `TBF_SD_SYMS;
    endsequence
    // once an abort's start delimiter is taken the end delimiter is offered at once
    sequence next_out_ed_s;
        tx_valid_o && tx_sym_o == `TBF_ED_SYMS;
    endsequence

    sd_pattern_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (tx_st_q == TX_SD && out_free) |=> tx_valid_o && tx_sym_o == `TBF_SD_SYMS)
        else $error("start delimiter symbols wrong");
    abort_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (sd_out_s ##0 abort_q) |=> next_out_ed_s)
        else $error("abort not followed by end delimiter");
    pre_min_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (tx_st_q == TX_SD && out_free) |-> pre_sent_q >= PRE_MIN && pre_sent_q != 8'h00)
        else $error("preamble too short");
    claim_pre_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (tx_st_q == TX_IDLE && out_free && tx_valid_i && !tx_abort_i && is_claim)
        |=> pre_left_q == PRE_MIN)
        else $error("claim preamble not minimum");
    hunt_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_st_q == RX_HUNT |-> !f_push)
        else $error("push outside a frame");
    abort_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && rx_st_q == RX_FRAME && is_ed && cnt_q == '0) |-> !f_push)
        else $error("abort delivered");
    good_fcs_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (f_push && f_word[9] && f_word[8]) |-> rx_fcs_ok_i && cnt_q >= min_len)
        else $error("good end without valid frame");
    claim_class_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && rx_st_q == RX_FRAME && is_dat && cnt_q == '0 && rx_byte == 8'h00)
        |=> rx_class_o == FC_CLAIM && rx_windows_o == 3'h0)
        else $error("claim token misclassified");
    windows_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && rx_st_q == RX_FRAME && is_dat && cnt_q == '0 && rx_byte == 8'h03)
        |=> rx_class_o == FC_WHO && rx_windows_o == 3'h3)
        else $error("response windows wrong");
endmodule // tbf_framer

/* File: tbf_modem_model.sv */
// Purpose: modem stand-in on the symbol side of the framer
// Assumes: one symbol octet per handshake, [15:14] first
// Notes:   released receive lines show the inverse of the last octet
`timescale 1ns/1ns
module tbf_modem_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] tx_sym_i,
    input  wire logic        tx_valid_i,
    output logic             tx_ready_o,
    output logic [15:0]      rx_sym_o,
    output logic             rx_valid_o,
    input  wire logic        rx_ready_i
);
    logic [15:0] txq[$];
    logic        slow = 1'b0;

    initial
    begin
        tx_ready_o = 1'b0;
        rx_sym_o   = 16'h0000;
        rx_valid_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // slow mode takes every other cycle, so held symbols are exercised
    always @(posedge clk_i)
    begin
        if (tx_valid_i && tx_ready_o && !rst_i)
            txq.push_back(tx_sym_i);
        tx_ready_o <= rst_i ? 1'b0 : (slow ? !tx_ready_o : 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // octets held until taken or 2000 cycles pass; framing is the caller's
    task automatic send_octs(input logic [15:0] q[$]);
        int n;
        @(posedge clk_i);
        foreach (q[i])
        begin
            rx_sym_o   <= q[i];
            rx_valid_o <= 1'b1;
            n = 0;
            do
            begin
                @(negedge clk_i);
                n++;
            end
            while (!rx_ready_i && n < 2000);
            @(posedge clk_i);
        end
        rx_valid_o <= 1'b0;
        rx_sym_o   <= ~q[q.size()-1];
    endtask
endmodule // tbf_modem_model

/* File: tb_top.sv */
// Purpose: self-checking bench of the frame block
// Assumes: short gap parameter, 10 Mb/s minimum preamble of 3
// Notes:   pad symbol coding is not checked, only its count
`timescale 1ns/1ns
`include "tbf_defines.svh"
module tb_top import tbf_pkg::*; ;
    localparam int PRE_MIN = 3;
    typedef logic [7:0] tbf_oq_t[$];
    logic        clk_i          = 1'b0;
    logic        rst_i          = 1'b1;
    logic        addr_long_i    = 1'b0;
    logic [7:0]  post_sil_pre_i = 8'h05;
    logic [7:0]  tx_data_i      = 8'h00;
    logic        tx_valid_i     = 1'b0;
    logic        tx_last_i      = 1'b0;
    logic        tx_abort_i     = 1'b0;
    logic        rx_fcs_ok_i    = 1'b1;
    logic        rx_ready_i     = 1'b0;
    logic        tx_ready_o;
    logic [15:0] tx_sym_o;
    logic        tx_valid_o;
    logic        tx_ready_i;
    logic [15:0] rx_sym_i;
    logic        rx_valid_i;
    logic        rx_ready_o;
    logic [7:0]  rx_data_o;
    logic        rx_end_o;
    logic        rx_good_o;
    logic        rx_valid_o;
    tbf_class_e  rx_class_o;
    logic [2:0]  rx_windows_o;
    logic [9:0]  rxq[$];
    int          errors   = 0;
    int          compares = 0;
    int          cycles   = 0;

    tbf_framer #(.RATE_MBPS(10), .GAP_CYC(8), .DEPTH(4)) DUT (
        .clk_i, .rst_i, .addr_long_i, .post_sil_pre_i, .tx_data_i, .tx_valid_i, .tx_last_i,
        .tx_ready_o, .tx_abort_i, .tx_sym_o, .tx_valid_o, .tx_ready_i, .rx_sym_i, .rx_valid_i,
        .rx_ready_o, .rx_fcs_ok_i, .rx_data_o, .rx_end_o, .rx_good_o, .rx_valid_o, .rx_ready_i,
        .rx_class_o, .rx_windows_o
    );
    tbf_modem_model modem (
        .clk_i, .rst_i, .tx_sym_i(tx_sym_o), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i),
        .rx_sym_o(rx_sym_i), .rx_valid_o(rx_valid_i), .rx_ready_i(rx_ready_o)
    );

    initial
    begin
        forever #5 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // delivered words and hang guard
    always @(posedge clk_i)
    begin
        if (rx_valid_o && rx_ready_i)
            rxq.push_back({rx_end_o, rx_good_o, rx_data_o});
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            print_verdict();
        end
    end

    function automatic logic [15:0] syms(input logic [7:0] b);
        logic [15:0] s;
        for (int i = 0; i < 8; i++)
            s[2*i +: 2] = {1'b0, b[i]};
        return s;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_cls(input tbf_class_e got, input tbf_class_e exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // transmit side: pad count, delimiters, body back to back
    task automatic check_tx(input tbf_oq_t b, input int npre);
        int idx;
        int last;
        idx  = -1;
        last = npre + b.size() + 1;
        foreach (modem.txq[i])
            if (idx < 0 && modem.txq[i] === `TBF_SD_SYMS)
                idx = i;
        chk(16'(modem.txq.size()), 16'(last + 1));
        chk(16'(idx), 16'(npre));
        chk(modem.txq[npre], `TBF_SD_SYMS);
        foreach (b[i])
            chk(modem.txq[npre+1+i], syms(b[i]));
        chk(modem.txq[last] & `TBF_ED_MASK, `TBF_ED_SYMS & `TBF_ED_MASK);
    endtask

    task automatic wait_tx(input int total);
        int n;
        n = 0;
        while (modem.txq.size() < total && n < 400)
        begin
            @(posedge clk_i);
            n++;
        end
    endtask

    task automatic tx_frame(input tbf_oq_t b, input int npre);
        int n;
        modem.txq.delete();
        foreach (b[i])
        begin
            tx_data_i  <= b[i];
            tx_valid_i <= 1'b1;
            tx_last_i  <= (i == b.size() - 1);
            n = 0;
            do
            begin
                @(negedge clk_i);
                n++;
            end
            while (!tx_ready_o && n < 200);
            @(posedge clk_i);
        end
        tx_valid_i <= 1'b0;
        tx_last_i  <= 1'b0;
        wait_tx(npre + b.size() + 2);
        check_tx(b, npre);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // receive side: junk before the frame must be ignored, check octets withheld
    task automatic rx_frame(input tbf_oq_t b, input logic good, input tbf_class_e cls, input logic [2:0] win);
        logic [15:0] q[$];
        logic [9:0]  e[$];
        int          n;
        rxq.delete();
        q = '{16'h5555, `TBF_ED_SYMS, 16'h0000, `TBF_SD_SYMS};
        foreach (b[i])
            q.push_back(syms(b[i]));
        q.push_back(`TBF_ED_SYMS);
        for (int i = 0; i + 4 < b.size(); i++)
            e.push_back({2'b00, b[i]});
        if (b.size() > 0)
            e.push_back({1'b1, good, 8'h00});
        modem.send_octs(q);
        n = 0;
        while (!(rxq.size() > 0 && rxq[$][9]) && n < 200)
        begin
            @(posedge clk_i);
            n++;
        end
        if (b.size() > 8191)
            chk(16'(rxq[$]), 16'h0200);
        else
        begin
            chk(16'(rxq.size()), 16'(e.size()));
            foreach (e[i])
                chk(16'(rxq[i]), 16'(e[i]));
        end
        chk_cls(rx_class_o, cls);
        chk(16'(rx_windows_o), 16'(win));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset;
        repeat (3) @(posedge clk_i);
        rst_i      <= 1'b0;
        rx_ready_i <= 1'b1;
        @(negedge clk_i);
        chk(16'(tx_valid_o), 16'h0000);
        chk(16'(rx_ready_o), 16'h0001);
        chk_cls(rx_class_o, FC_NONE);
        @(posedge clk_i);
        $display("test_reset done");
    endtask

    task automatic test_tx;
        repeat (20) @(posedge clk_i);
        modem.slow = 1'b1;
        tx_frame('{8'h08, 8'h12, 8'h34, 8'h56, 8'h78, 8'hDE, 8'hAD, 8'hBE, 8'hEF}, 5);
        modem.slow = 1'b0;
        tx_frame('{8'h47, 8'h12, 8'h34, 8'h56, 8'h78, 8'hA5, 8'h01, 8'h02, 8'h03, 8'h04}, PRE_MIN);
        repeat (20) @(posedge clk_i);
        tx_frame('{8'h00, 8'h12, 8'h34, 8'h56, 8'h78, 8'h01, 8'h02, 8'h03, 8'h04}, PRE_MIN);
        repeat (20) @(posedge clk_i);
        modem.txq.delete();
        tx_abort_i <= 1'b1;
        @(posedge clk_i);
        tx_abort_i <= 1'b0;
        wait_tx(PRE_MIN + 2);
        check_tx('{}, PRE_MIN);
        $display("test_tx done");
    endtask

    task automatic test_rx_classes;
        logic [7:0] fc[8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0C, 8'h47};
        tbf_class_e cl[8] = '{FC_CLAIM, FC_SOL1, FC_SOL2, FC_WHO, FC_RESOLVE, FC_TOKEN, FC_SETSUCC, FC_LLC};
        logic [2:0] w[8]  = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h0, 3'h0};
        foreach (fc[i])
            rx_frame('{fc[i], 8'h12, 8'h34, 8'h56, 8'h78, 8'h01, 8'h02, 8'h03, 8'h04}, 1'b1, cl[i], w[i]);
        $display("test_rx_classes done");
    endtask

    task automatic test_rx_faults;
        tbf_oq_t big;
        rx_frame('{8'h80, 8'h12, 8'h34, 8'h56, 8'h78, 8'h01, 8'h02, 8'h03, 8'h04}, 1'b1, FC_OTHER, 3'h0);
        rx_frame('{}, 1'b1, FC_OTHER, 3'h0);
        rx_fcs_ok_i <= 1'b0;
        rx_frame('{8'h08, 8'h12, 8'h34, 8'h56, 8'h78, 8'h01, 8'h02, 8'h03, 8'h04}, 1'b0, FC_TOKEN, 3'h0);
        rx_fcs_ok_i <= 1'b1;
        addr_long_i <= 1'b1;
        // two-octet addresses on a six-octet bus leave the frame too short
        rx_frame('{8'h08, 8'h12, 8'h34, 8'h56, 8'h78, 8'h01, 8'h02, 8'h03, 8'h04}, 1'b0, FC_TOKEN, 3'h0);
        addr_long_i <= 1'b0;
        big.push_back(8'h47);
        repeat (8191) big.push_back(8'h3C);
        rx_frame(big, 1'b0, FC_LLC, 3'h0);
        $display("test_rx_faults done");
    endtask

    task automatic test_rx_stall;
        rx_ready_i <= 1'b0;
        fork
            rx_frame('{8'h47, 8'h12, 8'h34, 8'h56, 8'h78, 8'h11, 8'h22, 8'h33, 8'h44, 8'h01, 8'h02, 8'h03, 8'h04},
                     1'b1, FC_LLC, 3'h0);
            begin
                repeat (40) @(negedge clk_i);
                chk(16'(rx_ready_o), 16'h0000);
                @(posedge clk_i);
                rx_ready_i <= 1'b1;
            end
        join
        $display("test_rx_stall done");
    endtask

    task automatic print_verdict;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        test_reset();
        test_tx();
        test_rx_classes();
        test_rx_faults();
        test_rx_stall();
        print_verdict();
    end
endmodule // tb_top
